// ---- verilog/cache_ctl_pkg.sv ----
package cache_ctl_pkg;
    localparam logic [7:0] CTL1_IDX = 8'hd0;
    localparam logic [7:0] CTL2_IDX = 8'hd1;
    localparam logic [7:0] CTL3_IDX = 8'hd2;
    localparam logic [7:0] STAT_IDX = 8'hd3;
    localparam logic [11:0] CTL1_ADDR = {2'b00, CTL1_IDX, 2'b00};
    localparam logic [11:0] CTL2_ADDR = {2'b00, CTL2_IDX, 2'b00};
    localparam logic [11:0] CTL3_ADDR = {2'b00, CTL3_IDX, 2'b00};
    localparam logic [11:0] STAT_ADDR = {2'b00, STAT_IDX, 2'b00};
    localparam logic [7:0] CTL1_RST = 8'hc0;
    localparam logic [7:0] CTL2_RST = 8'h41;
    localparam logic [7:0] CTL3_RST = 8'h00;
    localparam int C1_CS_BETWEEN = 7;
    localparam int C1_SUSP_DRIVE = 6;
    localparam int C1_ENGAGE = 5;
    localparam int C1_WR_ZERO_WS = 2;
    localparam int C1_BURST_WS = 1;
    localparam int C1_FIRST_WS = 0;
    localparam int C2_TAG7 = 5;
    localparam int C2_ONE_BANK = 4;
    localparam int BANK_ADDR_BIT = 3;
    localparam logic [5:0] SEG_C_FIRST = 6'h30;
    localparam logic [5:0] SEG_C_LAST = 6'h37;
    localparam logic [5:0] SEG_E_FIRST = 6'h38;
    localparam logic [5:0] SEG_E_LAST = 6'h3b;
    localparam logic [1:0] FIRST_CLKS_FAST = 2'h2;
    localparam logic [1:0] FIRST_CLKS_SLOW = 2'h3;
    localparam logic [1:0] BURST_CLKS_FAST = 2'h1;
    localparam logic [1:0] BURST_CLKS_SLOW = 2'h2;
    localparam logic [1:0] WRITE_CLKS_FAST = 2'h1;
    localparam logic [1:0] WRITE_CLKS_SLOW = 2'h2;
    localparam logic [1:0] LAST_BEAT = 2'h3;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RD_FIRST = 2'b01,
        ST_RD_BURST = 2'b10,
        ST_WRITE = 2'b11
    } cyc_state_t;
endpackage

// ---- verilog/secondary_cache_control.sv ----
`timescale 1ns/1ps
module secondary_cache_control import cache_ctl_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sa0_strap,
    input wire logic acc_start,
    input wire logic acc_write,
    input wire logic [19:0] acc_addr,
    input wire logic stop_grant,
    input wire logic suspend,
    input wire logic sd_xfer_active,
    input wire logic sd_to_sd,
    input wire logic [1:0] sd_lane_en,
    input wire logic rtc_select_n,
    input wire logic keyboard_select_n,
    input wire logic dram_write_strobe_n,
    output logic xcvr_direction,
    output logic rtc_pin_n,
    output logic kbd_pin_n,
    output logic dwe_pin_n,
    output logic [3:0] cache_bank_selects_n,
    output logic cache_ctl_oe_n,
    output logic tag_select_n,
    output logic tag_width7,
    output logic single_bank,
    output logic cache_support,
    output logic cache_engaged,
    output logic acc_bypass,
    output logic acc_ready,
    output logic acc_done
);
    logic [7:0] ctl1_r, ctl1_nxt, ctl2_r, ctl2_nxt, ctl3_r, ctl3_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic sa0_s1_r, sa0_s2_r, strap_r, strap_nxt, strap_done_r;
    cyc_state_t st_r, st_nxt;
    logic [1:0] cnt_r, cnt_nxt, beat_r, beat_nxt;
    logic bank_r, bank_nxt, rdy_r, rdy_nxt, done_r, done_nxt, byp_r, byp_nxt;
    logic [3:0] bsel_n_r, bsel_n_nxt;
    logic tag_n_r, tag_n_nxt, oe_n_r, oe_n_nxt;
    logic dir_r, dir_nxt, rtc_r, rtc_nxt, kbd_r, kbd_nxt, dwe_r, dwe_nxt;
    logic engaged, mapped, setup, cs_hold;
    logic [1:0] first_clks, burst_clks, write_clks;

    function automatic logic seg_cacheable(input logic [19:0] a, input logic [7:0] c2, input logic [7:0] c3);
        logic [5:0] seg;
        seg = a[19:14];
        if (seg >= SEG_C_FIRST && seg <= SEG_C_LAST) begin
            seg_cacheable = c3[seg[2:0]];
        end else if (seg >= SEG_E_FIRST && seg <= SEG_E_LAST) begin
            seg_cacheable = c2[seg[1:0]];
        end else begin
            seg_cacheable = 1'b1;
        end
    endfunction

    // Register file
    assign setup = psel & ~penable;
    assign mapped = (paddr == CTL1_ADDR) | (paddr == CTL2_ADDR) | (paddr == CTL3_ADDR) | (paddr == STAT_ADDR);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = prdata_r;

    always_comb begin
        ctl1_nxt = ctl1_r;
        ctl2_nxt = ctl2_r;
        ctl3_nxt = ctl3_r;
        prdata_nxt = prdata_r;
        if (psel & penable & pwrite) begin
            if (paddr == CTL1_ADDR) begin
                ctl1_nxt = pwdata[7:0];
            end
            if (paddr == CTL2_ADDR) begin
                ctl2_nxt = pwdata[7:0];
            end
            if (paddr == CTL3_ADDR) begin
                ctl3_nxt = pwdata[7:0];
            end
        end
        if (setup & ~pwrite) begin
            case (paddr)
                CTL1_ADDR: prdata_nxt = {24'h00_0000, ctl1_r};
                CTL2_ADDR: prdata_nxt = {24'h00_0000, ctl2_r};
                CTL3_ADDR: prdata_nxt = {24'h00_0000, ctl3_r};
                STAT_ADDR: prdata_nxt = {28'h000_0000, st_r != ST_IDLE, engaged, strap_r, strap_done_r};
                default: prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl1_r <= CTL1_RST;
            ctl2_r <= CTL2_RST;
            ctl3_r <= CTL3_RST;
            prdata_r <= 32'h0000_0000;
        end else begin
            ctl1_r <= ctl1_nxt;
            ctl2_r <= ctl2_nxt;
            ctl3_r <= ctl3_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // Strap capture once after reset release
    always_comb begin
        strap_nxt = strap_r;
        if (!strap_done_r) begin
            strap_nxt = ~sa0_s2_r;
        end
    end

    // Keeps sampling through reset, so strap is settled at release
    always_ff @(posedge pclk) begin
        sa0_s1_r <= sa0_strap;
        sa0_s2_r <= sa0_s1_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_r <= 1'b0;
            strap_done_r <= 1'b0;
        end else begin
            strap_r <= strap_nxt;
            strap_done_r <= 1'b1;
        end
    end

    assign engaged = strap_r & strap_done_r & ctl1_r[C1_ENGAGE];
    assign first_clks = ctl1_r[C1_FIRST_WS] ? FIRST_CLKS_SLOW : FIRST_CLKS_FAST;
    assign burst_clks = ctl1_r[C1_BURST_WS] ? BURST_CLKS_SLOW : BURST_CLKS_FAST;
    assign write_clks = ctl1_r[C1_WR_ZERO_WS] ? WRITE_CLKS_FAST : WRITE_CLKS_SLOW;

    // Cache cycle sequencer
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        beat_nxt = beat_r;
        bank_nxt = bank_r;
        rdy_nxt = 1'b0;
        done_nxt = 1'b0;
        byp_nxt = 1'b0;
        case (st_r)
            ST_IDLE: begin
                if (acc_start) begin
                    if (!engaged || stop_grant || suspend || !seg_cacheable(acc_addr, ctl2_r, ctl3_r)) begin
                        byp_nxt = 1'b1;
                    end else begin
                        bank_nxt = acc_addr[BANK_ADDR_BIT];
                        beat_nxt = 2'h0;
                        if (acc_write) begin
                            st_nxt = ST_WRITE;
                            cnt_nxt = write_clks - 2'h1;
                        end else begin
                            st_nxt = ST_RD_FIRST;
                            cnt_nxt = first_clks - 2'h1;
                        end
                    end
                end
            end
            ST_RD_FIRST: begin
                if (cnt_r == 2'h0) begin
                    rdy_nxt = 1'b1;
                    beat_nxt = 2'h1;
                    cnt_nxt = burst_clks - 2'h1;
                    st_nxt = ST_RD_BURST;
                end else begin
                    cnt_nxt = cnt_r - 2'h1;
                end
            end
            ST_RD_BURST: begin
                if (cnt_r == 2'h0) begin
                    rdy_nxt = 1'b1;
                    if (beat_r == LAST_BEAT) begin
                        done_nxt = 1'b1;
                        st_nxt = ST_IDLE;
                    end else begin
                        beat_nxt = beat_r + 2'h1;
                        cnt_nxt = burst_clks - 2'h1;
                    end
                end else begin
                    cnt_nxt = cnt_r - 2'h1;
                end
            end
            ST_WRITE: begin
                if (cnt_r == 2'h0) begin
                    rdy_nxt = 1'b1;
                    done_nxt = 1'b1;
                    st_nxt = ST_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 2'h1;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_IDLE;
            cnt_r <= 2'h0;
            beat_r <= 2'h0;
            bank_r <= 1'b0;
            rdy_r <= 1'b0;
            done_r <= 1'b0;
            byp_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            beat_r <= beat_nxt;
            bank_r <= bank_nxt;
            rdy_r <= rdy_nxt;
            done_r <= done_nxt;
            byp_r <= byp_nxt;
        end
    end

    // Chip selects held low when idle only with bit7 clear
    assign cs_hold = (st_nxt != ST_IDLE)
        || (!ctl1_r[C1_CS_BETWEEN] && engaged && !stop_grant && !suspend);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_bank
            always_comb begin
                bsel_n_nxt[gi] = 1'b1;
                if (cs_hold && !stop_grant && !suspend) begin
                    bsel_n_nxt[gi] = !(ctl2_r[C2_ONE_BANK] || st_nxt == ST_IDLE
                        || bank_nxt == (gi >= 2));
                end
            end
        end
    endgenerate

    // Pin outputs and transceiver control
    always_comb begin
        tag_n_nxt = !(cs_hold && !stop_grant && !suspend);
        oe_n_nxt = !strap_r || (suspend && !ctl1_r[C1_SUSP_DRIVE]);
        dir_nxt = dir_r;
        if (sd_xfer_active) begin
            dir_nxt = sd_to_sd;
        end
        if (strap_r) begin
            rtc_nxt = !(sd_xfer_active && sd_lane_en[0]);
            kbd_nxt = !(sd_xfer_active && sd_lane_en[1]);
            dwe_nxt = dram_write_strobe_n & keyboard_select_n;
        end else begin
            rtc_nxt = rtc_select_n;
            kbd_nxt = keyboard_select_n;
            dwe_nxt = dram_write_strobe_n;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bsel_n_r <= 4'hf;
            tag_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            dir_r <= 1'b0;
            rtc_r <= 1'b1;
            kbd_r <= 1'b1;
            dwe_r <= 1'b1;
        end else begin
            bsel_n_r <= bsel_n_nxt;
            tag_n_r <= tag_n_nxt;
            oe_n_r <= oe_n_nxt;
            dir_r <= dir_nxt;
            rtc_r <= rtc_nxt;
            kbd_r <= kbd_nxt;
            dwe_r <= dwe_nxt;
        end
    end

    assign cache_bank_selects_n = bsel_n_r;
    assign tag_select_n = tag_n_r;
    assign cache_ctl_oe_n = oe_n_r;
    assign xcvr_direction = dir_r;
    assign rtc_pin_n = rtc_r;
    assign kbd_pin_n = kbd_r;
    assign dwe_pin_n = dwe_r;
    assign tag_width7 = ctl2_r[C2_TAG7];
    assign single_bank = ctl2_r[C2_ONE_BANK];
    assign cache_support = strap_r;
    assign cache_engaged = engaged;
    assign acc_bypass = byp_r;
    assign acc_ready = rdy_r;
    assign acc_done = done_r;

    // Checks
    sequence s_hit_start(logic wr);
        acc_start && acc_write == wr && st_r == ST_IDLE && engaged && !stop_grant && !suspend
            && seg_cacheable(acc_addr, ctl2_r, ctl3_r);
    endsequence

    a_dir_to_sd: assert property (@(posedge pclk) disable iff (!presetn)
        sd_xfer_active && sd_to_sd |=> xcvr_direction) else $error("direction not high");
    a_dir_to_cd: assert property (@(posedge pclk) disable iff (!presetn)
        sd_xfer_active && !sd_to_sd |=> !xcvr_direction) else $error("direction not low");
    a_engage_strap: assert property (@(posedge pclk) disable iff (!presetn)
        cache_engaged |-> cache_support && ctl1_r[C1_ENGAGE]) else $error("engaged without strap");
    a_cs_idle_low: assert property (@(posedge pclk) disable iff (!presetn)
        !ctl1_r[C1_CS_BETWEEN] && engaged && !stop_grant && !suspend |=> !tag_select_n)
        else $error("tag select dropped while idle");
    a_cs_between_high: assert property (@(posedge pclk) disable iff (!presetn)
        ctl1_r[C1_CS_BETWEEN] && st_r == ST_IDLE && !acc_start |=> tag_select_n && cache_bank_selects_n == 4'hf)
        else $error("selects held between accesses");
    a_susp_float: assert property (@(posedge pclk) disable iff (!presetn)
        suspend |=> tag_select_n && (cache_ctl_oe_n == (!cache_support || !$past(ctl1_r[C1_SUSP_DRIVE]))))
        else $error("suspend control state wrong");
    a_write_wait: assert property (@(posedge pclk) disable iff (!presetn)
        s_hit_start(1'b1) ##0 !ctl1_r[C1_WR_ZERO_WS] |-> ##1 !acc_ready ##1 !acc_ready ##1 acc_ready)
        else $error("write wait state wrong");
    a_write_zero_ws: assert property (@(posedge pclk) disable iff (!presetn)
        s_hit_start(1'b1) ##0 ctl1_r[C1_WR_ZERO_WS] |-> ##1 !acc_ready ##1 acc_ready)
        else $error("zero wait write wrong");
    a_first_read: assert property (@(posedge pclk) disable iff (!presetn)
        s_hit_start(1'b0) ##0 !ctl1_r[C1_FIRST_WS] |-> ##3 acc_ready) else $error("first read not two clocks");
    a_first_read_slow: assert property (@(posedge pclk) disable iff (!presetn)
        s_hit_start(1'b0) ##0 ctl1_r[C1_FIRST_WS] |-> ##3 !acc_ready ##1 acc_ready)
        else $error("first read not three clocks");
    a_burst_gap: assert property (@(posedge pclk) disable iff (!presetn)
        acc_ready && st_r == ST_RD_BURST && ctl1_r[C1_BURST_WS] |=> !acc_ready ##1 acc_ready)
        else $error("burst spacing wrong");
    a_bypass_seg: assert property (@(posedge pclk) disable iff (!presetn)
        acc_start && st_r == ST_IDLE && !seg_cacheable(acc_addr, ctl2_r, ctl3_r) |=> acc_bypass && st_r == ST_IDLE)
        else $error("non-cacheable access used cache");
    a_one_bank: assert property (@(posedge pclk) disable iff (!presetn)
        (ctl2_r[C2_ONE_BANK] && !stop_grant && !suspend) ##1 (st_r != ST_IDLE) |-> cache_bank_selects_n == 4'h0)
        else $error("single bank not all selected");
    a_byte_en: assert property (@(posedge pclk) disable iff (!presetn)
        strap_r && sd_xfer_active |=> rtc_pin_n == !$past(sd_lane_en[0]) && kbd_pin_n == !$past(sd_lane_en[1]))
        else $error("byte enables wrong");
endmodule

// ---- bench/cache_sram_model.sv ----
`timescale 1ns/1ps
module cache_sram_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] cache_bank_selects_n,
    input wire logic tag_select_n,
    input wire logic cache_ctl_oe_n,
    input wire logic dwe_pin_n,
    input wire logic aen,
    output logic kbd_decoded_n,
    output logic [4:0] sram_cs_level
);
    logic [4:0] last_r;
    // Shared pin qualified by address enable outside the device
    assign kbd_decoded_n = dwe_pin_n | aen;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_r <= 5'h1f;
        end else if (!cache_ctl_oe_n) begin
            last_r <= {tag_select_n, cache_bank_selects_n};
        end
    end
    // Floating selects settle away from their last driven level
    assign sram_cs_level = cache_ctl_oe_n ? ~last_r : {tag_select_n, cache_bank_selects_n};
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import cache_ctl_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic sa0_strap = 1'b0;
    logic acc_start = 1'b0, acc_write = 1'b0, stop_grant = 1'b0, suspend = 1'b0, aen = 1'b1;
    logic [19:0] acc_addr = 20'h0_0000;
    logic sd_xfer_active = 1'b0, sd_to_sd = 1'b0, rtc_select_n = 1'b1, keyboard_select_n = 1'b1;
    logic dram_write_strobe_n = 1'b1;
    logic [1:0] sd_lane_en = 2'b00;
    logic [31:0] prdata;
    logic pready, pslverr, xcvr_direction, rtc_pin_n, kbd_pin_n, dwe_pin_n, cache_ctl_oe_n, tag_select_n;
    logic tag_width7, single_bank, cache_support, cache_engaged, acc_bypass, acc_ready, acc_done;
    logic kbd_decoded_n;
    logic [3:0] cache_bank_selects_n;
    logic [4:0] sram_cs_level;
    logic [7:0] c1r = 8'hc0, c2r = 8'h41, c3r = 8'h00;
    logic [31:0] rng = 32'h0000_f3f3;
    int fail_count = 0, comparisons = 0, cycles = 0;

    always #20 pclk = ~pclk;

    secondary_cache_control i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sa0_strap,
        .acc_start, .acc_write, .acc_addr, .stop_grant, .suspend, .sd_xfer_active, .sd_to_sd, .sd_lane_en,
        .rtc_select_n, .keyboard_select_n, .dram_write_strobe_n, .xcvr_direction, .rtc_pin_n, .kbd_pin_n,
        .dwe_pin_n, .cache_bank_selects_n, .cache_ctl_oe_n, .tag_select_n, .tag_width7, .single_bank,
        .cache_support, .cache_engaged, .acc_bypass, .acc_ready, .acc_done
    );
    cache_sram_model i_sram (
        .pclk, .presetn, .cache_bank_selects_n, .tag_select_n, .cache_ctl_oe_n, .dwe_pin_n, .aen,
        .kbd_decoded_n, .sram_cs_level
    );

    function automatic logic [31:0] next_rand();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    function automatic logic seg_ok(input logic [19:0] a);
        logic [5:0] s;
        s = a[19:14];
        if (s >= SEG_C_FIRST && s <= SEG_C_LAST) return c3r[s - SEG_C_FIRST];
        if (s >= SEG_E_FIRST && s <= SEG_E_LAST) return c2r[s - SEG_E_FIRST];
        return 1'b1;
    endfunction

    function automatic logic [3:0] exp_sel(input logic [19:0] a);
        if (c2r[4]) return 4'h0;
        return a[3] ? 4'b0011 : 4'b1100;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic ee);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0000_0000, rd, err);
        check(rd, e);
        check(err, ee);
    endtask

    task automatic set_regs(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        logic [31:0] rd;
        logic err;
        apb(1'b1, CTL1_ADDR, {24'h00_0000, a}, rd, err);
        apb(1'b1, CTL2_ADDR, {24'h00_0000, b}, rd, err);
        apb(1'b1, CTL3_ADDR, {24'h00_0000, c}, rd, err);
        c1r = a;
        c2r = b;
        c3r = c;
    endtask

    task automatic run_acc(input logic w, input logic [19:0] a);
        int nr;
        int last;
        logic byp;
        byp = !c1r[5] || stop_grant || !seg_ok(a);
        nr = 0;
        last = 0;
        acc_start <= 1'b1;
        acc_write <= w;
        acc_addr <= a;
        for (int n = 1; n <= 16; n++) begin
            @(posedge pclk);
            acc_start <= 1'b0;
            #1;
            if (n == 1) check(acc_bypass, byp);
            if (n == 1 && !byp && c1r[7]) check({tag_select_n, cache_bank_selects_n}, {1'b0, exp_sel(a)});
            if (acc_ready === 1'b1 && !byp) begin
                if (nr == 0) check(n, w ? (c1r[2] ? 2 : 3) : (c1r[0] ? 4 : 3));
                else check(n - last, c1r[1] ? 2 : 1);
                nr++;
                last = n;
                check(acc_done, nr == (w ? 1 : 4));
            end
        end
        if (!byp) check(nr, w ? 1 : 4);
        if (c1r[5]) check({tag_select_n, cache_bank_selects_n}, (c1r[7] || stop_grant) ? 5'h1f : 5'h00);
        @(posedge pclk);
    endtask

    initial begin
        logic [31:0] v;
        logic act;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        rd_chk(CTL1_ADDR, 32'h0000_00c0, 1'b0);
        rd_chk(CTL2_ADDR, 32'h0000_0041, 1'b0);
        rd_chk(CTL3_ADDR, 32'h0000_0000, 1'b0);
        rd_chk(12'h004, 32'h0000_0000, 1'b1);
        rd_chk(STAT_ADDR, 32'h0000_0003, 1'b0);
        check(cache_support, 1'b1);
        $display("test reset_values done");
        for (int i = 0; i < 6; i++) begin
            v = next_rand();
            set_regs(v[7:0], v[15:8], v[23:16]);
            rd_chk(CTL1_ADDR, {24'h00_0000, c1r}, 1'b0);
            rd_chk(CTL2_ADDR, {24'h00_0000, c2r}, 1'b0);
            rd_chk(CTL3_ADDR, {24'h00_0000, c3r}, 1'b0);
            check({tag_width7, single_bank, cache_engaged}, {c2r[5], c2r[4], c1r[5]});
        end
        $display("test register_rw done");
        for (int i = 0; i < 8; i++) begin
            v = next_rand();
            set_regs({i[0], 2'b01, 2'b00, i[2:0]}, v[7:0], v[15:8]);
            run_acc(1'b0, {4'h1, v[31:16]});
            run_acc(1'b1, {4'h2, v[31:16]});
        end
        $display("test access_timing done");
        v = next_rand();
        set_regs(8'ha0, v[7:0], v[15:8]);
        for (int s = 0; s < 12; s++) run_acc(s[0], {6'(s + 48), v[29:16]});
        $display("test segments done");
        set_regs(8'h00, 8'h0f, 8'hff);
        run_acc(1'b0, 20'h1_0000);
        set_regs(8'h20, 8'h0f, 8'hff);
        stop_grant <= 1'b1;
        repeat (2) @(posedge pclk);
        run_acc(1'b0, 20'h1_0000);
        stop_grant <= 1'b0;
        $display("test bypass done");
        for (int b = 0; b < 2; b++) begin
            set_regs({1'b0, b[0], 6'h20}, 8'h0f, 8'hff);
            suspend <= 1'b1;
            repeat (3) @(posedge pclk);
            #1;
            check(cache_ctl_oe_n, !b[0]);
            check(sram_cs_level, 5'h1f);
            @(posedge pclk);
            suspend <= 1'b0;
            repeat (3) @(posedge pclk);
            #1;
            check({cache_ctl_oe_n, tag_select_n, cache_bank_selects_n}, 6'h00);
            @(posedge pclk);
        end
        $display("test suspend done");
        for (int i = 0; i < 8; i++) begin
            v = next_rand();
            act = v[0] | i[0];
            sd_xfer_active <= act;
            sd_to_sd <= v[1];
            sd_lane_en <= v[3:2];
            rtc_select_n <= v[4];
            keyboard_select_n <= v[5];
            dram_write_strobe_n <= v[6];
            aen <= v[7];
            repeat (2) @(posedge pclk);
            #1;
            if (act) check(xcvr_direction, v[1]);
            check({rtc_pin_n, kbd_pin_n}, {~(act & v[2]), ~(act & v[3])});
            check({dwe_pin_n, kbd_decoded_n}, {v[6] & v[5], (v[6] & v[5]) | v[7]});
            @(posedge pclk);
        end
        $display("test transceiver done");
        wrap_up();
    end
endmodule
